// [ppm_mux.sv]
/*
  Pin function multiplexer for port 1 pin 7 and port 2 pins 0..6.
  Assumes control bits and peripheral signals come from logic on clk_i,
  and pin inputs come from the pad ring asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none
module ppm_mux (
  input  wire logic                          clk_i,
  input  wire logic                          reset_n_i,
  input  wire ppm_pkg::ppm_cfg_t             cfg_i,
  input  wire ppm_pkg::ppm_periph_t          periph_i,
  input  wire logic [ppm_pkg::PPM_PINS-1:0]  port_out_i,
  input  wire logic [ppm_pkg::PPM_PINS-1:0]  pin_in_i,
  output ppm_pkg::ppm_drive_t                pin_drive_o,
  output logic      [ppm_pkg::PPM_PINS-1:0]  port_in_o,
  output ppm_pkg::ppm_capture_t              capture_o,
  output logic                               resistor_connect_o,
  output logic                               crystal_connect_o
);
  import ppm_pkg::*;

  ppm_cfg_t            cfg_r;
  logic [PPM_PINS-1:0] pin_sync;
  ppm_drive_t          drive_nxt;
  logic [PPM_PINS-1:0] port_in_nxt;
  ppm_capture_t        capture_nxt;
  logic                resistor_nxt;
  logic                crystal_nxt;
  logic [PPM_PINS-1:0] sel_all;
  logic [PPM_PINS-1:0] dir_all;
  logic [PPM_PINS-1:0] ae_all;

  // Pad inputs through the synchroniser
  ppm_pin_sync u_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .pin_i     (pin_in_i),
    .pin_o     (pin_sync)
  );

  // Local copy of control bits with power-up defaults
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_r.port1_direction_bits                <= P1_DIR_RESET;
      cfg_r.port1_function_select_bits          <= P1_SEL_RESET;
      cfg_r.port2_direction_bits                <= P2_DIR_RESET;
      cfg_r.port2_function_select_bits          <= P2_SEL_RESET;
      cfg_r.converter_analog_enable_bits        <= AE_RESET;
      cfg_r.oscillator_external_resistor_select <= 1'b0;
      cfg_r.test_port_active                    <= 1'b0;
    end else begin
      cfg_r <= cfg_i;
    end
  end

  // Flattened per-slot views
  assign sel_all = {cfg_r.port2_function_select_bits, cfg_r.port1_function_select_bits};
  assign dir_all = {cfg_r.port2_direction_bits, cfg_r.port1_direction_bits};
  assign ae_all  = {2'h0, cfg_r.converter_analog_enable_bits, 1'b0};

  // Function selection per pin
  always_comb begin
    // Plain I/O default: drive only when not selected and direction set
    drive_nxt.out = port_out_i;
    drive_nxt.oe  = dir_all & ~sel_all;
    port_in_nxt   = pin_sync;
    capture_nxt   = '0;
    resistor_nxt  = 1'b0;
    crystal_nxt   = 1'b0;

    // Port 1 pin 7
    if (cfg_r.test_port_active) begin
      drive_nxt.out[PIN_P1_7] = periph_i.test_data_out;
      drive_nxt.oe[PIN_P1_7]  = periph_i.test_data_oe;
      capture_nxt.test_data_in = pin_sync[PIN_P1_7];
    end else if (sel_all[PIN_P1_7] && dir_all[PIN_P1_7]) begin
      drive_nxt.out[PIN_P1_7] = periph_i.timer_compare_out_2;
      drive_nxt.oe[PIN_P1_7]  = 1'b1;
    end

    // Port 2 pins 0..4 selected digital functions
    if (sel_all[PIN_P2_0] && dir_all[PIN_P2_0]) begin
      drive_nxt.out[PIN_P2_0] = periph_i.aux_clock;
      drive_nxt.oe[PIN_P2_0]  = 1'b1;
    end
    if (sel_all[PIN_P2_1]) begin
      if (dir_all[PIN_P2_1]) begin
        drive_nxt.out[PIN_P2_1] = periph_i.subsystem_master_clock;
        drive_nxt.oe[PIN_P2_1]  = 1'b1;
      end else begin
        capture_nxt.timer_alt_clock_in = pin_sync[PIN_P2_1];
      end
    end
    if (sel_all[PIN_P2_2]) begin
      if (dir_all[PIN_P2_2]) begin
        drive_nxt.out[PIN_P2_2] = periph_i.timer_compare_out_0;
        drive_nxt.oe[PIN_P2_2]  = 1'b1;
      end else begin
        capture_nxt.timer_capture_in_0b = pin_sync[PIN_P2_2];
      end
    end
    if (sel_all[PIN_P2_3]) begin
      if (dir_all[PIN_P2_3]) begin
        drive_nxt.out[PIN_P2_3] = periph_i.timer_compare_out_1;
        drive_nxt.oe[PIN_P2_3]  = 1'b1;
      end else begin
        capture_nxt.timer_capture_in_1b = pin_sync[PIN_P2_3];
      end
    end
    if (sel_all[PIN_P2_4] && dir_all[PIN_P2_4]) begin
      drive_nxt.out[PIN_P2_4] = periph_i.timer_compare_out_2;
      drive_nxt.oe[PIN_P2_4]  = 1'b1;
    end

    // Port 2 pin 5: resistor, ground drive, or plain I/O
    if (cfg_r.oscillator_external_resistor_select) begin
      resistor_nxt            = 1'b1;
      drive_nxt.oe[PIN_P2_5]  = 1'b0;
    end else if (sel_all[PIN_P2_5] && dir_all[PIN_P2_5]) begin
      drive_nxt.out[PIN_P2_5] = 1'b0;
      drive_nxt.oe[PIN_P2_5]  = 1'b1;
    end
    // Selected input on pin 5 reaches no peripheral: nothing assigned

    // Port 2 pin 6: crystal input whenever selected
    if (sel_all[PIN_P2_6]) begin
      crystal_nxt = 1'b1;
    end

    // Analog enable overrides everything on port 2 pins 0..4
    for (int i = 0; i < PPM_PINS; i++) begin
      if (ae_all[i]) begin
        drive_nxt.oe[i]  = 1'b0;
        drive_nxt.out[i] = 1'b0;
        port_in_nxt[i]   = 1'b0;
      end
    end
    if (ae_all[PIN_P2_1]) begin
      capture_nxt.timer_alt_clock_in = 1'b0;
    end
    if (ae_all[PIN_P2_2]) begin
      capture_nxt.timer_capture_in_0b = 1'b0;
    end
    if (ae_all[PIN_P2_3]) begin
      capture_nxt.timer_capture_in_1b = 1'b0;
    end
  end

  // Registered pin drive and input views
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_drive_o <= '0;
      port_in_o   <= '0;
      capture_o   <= '0;
    end else begin
      pin_drive_o <= drive_nxt;
      port_in_o   <= port_in_nxt;
      capture_o   <= capture_nxt;
    end
  end

  // Registered oscillator hookups
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      resistor_connect_o <= 1'b0;
      crystal_connect_o  <= 1'b1;
    end else begin
      resistor_connect_o <= resistor_nxt;
      crystal_connect_o  <= crystal_nxt;
    end
  end

  // Checks on the registered outputs
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_test_on;
    cfg_r.test_port_active;
  endsequence

  a_test_owns_pin: assert property (
    s_test_on |=> (pin_drive_o.out[PIN_P1_7] == $past(periph_i.test_data_out))
                  && (pin_drive_o.oe[PIN_P1_7] == $past(periph_i.test_data_oe)))
    else $error("test port not on port 1 pin 7");
  a_p17_compare_out: assert property (
    (!cfg_r.test_port_active && sel_all[PIN_P1_7] && dir_all[PIN_P1_7])
      |=> pin_drive_o.oe[PIN_P1_7]
          && (pin_drive_o.out[PIN_P1_7] == $past(periph_i.timer_compare_out_2)))
    else $error("port 1 pin 7 not driving compare 2");
  a_aux_clock_out: assert property (
    (sel_all[PIN_P2_0] && dir_all[PIN_P2_0] && !ae_all[PIN_P2_0])
      |=> pin_drive_o.out[PIN_P2_0] == $past(periph_i.aux_clock))
    else $error("aux clock missing");
  a_capture_0b_route: assert property (
    (sel_all[PIN_P2_2] && !dir_all[PIN_P2_2] && !ae_all[PIN_P2_2])
      |=> !pin_drive_o.oe[PIN_P2_2]
          && (capture_o.timer_capture_in_0b == $past(pin_sync[PIN_P2_2])))
    else $error("capture 0B route wrong");
  a_master_clock_out: assert property (
    (sel_all[PIN_P2_1] && dir_all[PIN_P2_1] && !ae_all[PIN_P2_1])
      |=> pin_drive_o.oe[PIN_P2_1]
          && (pin_drive_o.out[PIN_P2_1] == $past(periph_i.subsystem_master_clock)))
    else $error("master clock missing");
  a_capture_1b_route: assert property (
    (sel_all[PIN_P2_3] && !dir_all[PIN_P2_3] && !ae_all[PIN_P2_3])
      |=> capture_o.timer_capture_in_1b == $past(pin_sync[PIN_P2_3]))
    else $error("capture 1B route wrong");
  a_p24_compare_out: assert property (
    (sel_all[PIN_P2_4] && dir_all[PIN_P2_4] && !ae_all[PIN_P2_4])
      |=> pin_drive_o.out[PIN_P2_4] == $past(periph_i.timer_compare_out_2))
    else $error("port 2 pin 4 not driving compare 2");
  a_analog_no_drive: assert property (
    (|cfg_r.converter_analog_enable_bits)
      |=> (pin_drive_o.oe[PIN_P2_4:PIN_P2_0] & $past(cfg_r.converter_analog_enable_bits)) == '0)
    else $error("driver on analog pin");
  a_ground_drive: assert property (
    (!cfg_r.oscillator_external_resistor_select && sel_all[PIN_P2_5] && dir_all[PIN_P2_5])
      |=> pin_drive_o.oe[PIN_P2_5] && !pin_drive_o.out[PIN_P2_5] && !resistor_connect_o)
    else $error("ground drive missing");
  a_p25_input_idle: assert property (
    (!cfg_r.oscillator_external_resistor_select && sel_all[PIN_P2_5] && !dir_all[PIN_P2_5])
      |=> !pin_drive_o.oe[PIN_P2_5] && !resistor_connect_o)
    else $error("port 2 pin 5 selected input not idle");
  a_crystal_select: assert property (
    1'b1 |=> crystal_connect_o == $past(sel_all[PIN_P2_6]))
    else $error("crystal hookup wrong");
  a_analog_input_zero: assert property (
    (|cfg_r.converter_analog_enable_bits)
      |=> (port_in_o[PIN_P2_4:PIN_P2_0] & $past(cfg_r.converter_analog_enable_bits)) == '0)
    else $error("analog pin input not zero");

endmodule // ppm_mux
`default_nettype wire

// [ppm_pkg.sv]
/*
  Package for the port pin function multiplexer: pin indices, reset values
  of the configuration copy, and the carrier structs.
  Assumes one 250 MHz clock domain for all chip-side signals.
*/
`default_nettype none
package ppm_pkg;

  // Pin slots: slot 0 is port 1 pin 7, slots 1..7 are port 2 pins 0..6
  localparam int unsigned PPM_PINS    = 8;
  localparam int unsigned PIN_P1_7    = 0;
  localparam int unsigned PIN_P2_0    = 1;
  localparam int unsigned PIN_P2_1    = 2;
  localparam int unsigned PIN_P2_2    = 3;
  localparam int unsigned PIN_P2_3    = 4;
  localparam int unsigned PIN_P2_4    = 5;
  localparam int unsigned PIN_P2_5    = 6;
  localparam int unsigned PIN_P2_6    = 7;
  localparam int unsigned P2_PIN_BITS = 7;
  localparam int unsigned AE_BITS     = 5;

  // Reset values: all plain input except port 2 pin 6 selected for crystal
  localparam logic [P2_PIN_BITS-1:0] P2_SEL_RESET = 7'h40;
  localparam logic [P2_PIN_BITS-1:0] P2_DIR_RESET = 7'h00;
  localparam logic [AE_BITS-1:0]     AE_RESET     = 5'h00;
  localparam logic                   P1_SEL_RESET = 1'b0;
  localparam logic                   P1_DIR_RESET = 1'b0;
  localparam logic [PPM_PINS-1:0]    PIN_RESET    = 8'h00;

  // Pin-side drive of all slots
  typedef struct packed {
    logic [PPM_PINS-1:0] out;
    logic [PPM_PINS-1:0] oe;
  } ppm_drive_t;

  // Function-control bits from the port, converter and clock registers
  typedef struct packed {
    logic                   port1_direction_bits;
    logic                   port1_function_select_bits;
    logic [P2_PIN_BITS-1:0] port2_direction_bits;
    logic [P2_PIN_BITS-1:0] port2_function_select_bits;
    logic [AE_BITS-1:0]     converter_analog_enable_bits;
    logic                   oscillator_external_resistor_select;
    logic                   test_port_active;
  } ppm_cfg_t;

  // Peripheral signals driven out on pins
  typedef struct packed {
    logic timer_compare_out_0;
    logic timer_compare_out_1;
    logic timer_compare_out_2;
    logic aux_clock;
    logic subsystem_master_clock;
    logic test_data_out;
    logic test_data_oe;
  } ppm_periph_t;

  // Peripheral inputs taken from pins
  typedef struct packed {
    logic timer_capture_in_0b;
    logic timer_capture_in_1b;
    logic timer_alt_clock_in;
    logic test_data_in;
  } ppm_capture_t;

endpackage
`default_nettype wire

// [ppm_pin_sync.sv]
/*
  Three-stage input synchroniser for the pin inputs; a new level is taken
  once the second and third stages agree.
  Assumes asynchronous board levels on pin_i.
*/
`timescale 1ns/1ps
`default_nettype none
module ppm_pin_sync (
  input  wire logic                      clk_i,
  input  wire logic                      reset_n_i,
  input  wire logic [ppm_pkg::PPM_PINS-1:0] pin_i,
  output logic      [ppm_pkg::PPM_PINS-1:0] pin_o
);
  import ppm_pkg::*;

  genvar g;
  generate
    for (g = 0; g < PPM_PINS; g++) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      // Stage chain; s1 feeds only s2
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
        end else begin
          s1_r <= pin_i[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
        end
      end
      // Accept level when stages two and three agree
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          pin_o[g] <= PIN_RESET[g];
        end else if (s2_r == s3_r) begin
          pin_o[g] <= s3_r;
        end
      end
    end
  endgenerate
endmodule // ppm_pin_sync
`default_nettype wire

// [ppm_board.sv]
/*
  Board model for the multiplexed pins: resolves each pad from the
  device drive and the level that the board circuitry applies.
  Assumes the board drives every pad weakly, so a device drive wins.
*/
`timescale 1ns/1ps
`default_nettype none
module ppm_board (
  input  wire logic [7:0] out_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] level_i,
  output logic      [7:0] pad_o
);
  // Device drive wins; otherwise the board level shows on the pad
  always_comb begin
    pad_o = (oe_i & out_i) | (~oe_i & level_i);
  end
endmodule // ppm_board
`default_nettype wire

// [ppm_mux_bench.sv]
/*
  Self-checking bench for the pin function multiplexer.
  Assumes the board model file is compiled ahead of this one.
*/
`timescale 1ns/1ps
`default_nettype none
module ppm_mux_bench;
  import ppm_pkg::*;
  logic         clk_i = 1'b0;
  logic         reset_n_i = 1'b0;
  ppm_cfg_t     cfg;
  ppm_periph_t  per;
  ppm_drive_t   drv;
  ppm_capture_t cap;
  logic [7:0]   port_out;
  logic [7:0]   level;
  logic [7:0]   pad;
  logic [7:0]   port_in;
  logic         res_c;
  logic         xtal_c;
  int           miscompares = 0;
  int           n_compared = 0;

  // Clock, 4 ns period
  always #2 clk_i = ~clk_i;

  ppm_mux DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .cfg_i(cfg), .periph_i(per),
    .port_out_i(port_out), .pin_in_i(pad), .pin_drive_o(drv), .port_in_o(port_in),
    .capture_o(cap), .resistor_connect_o(res_c), .crystal_connect_o(xtal_c));
  ppm_board board (.out_i(drv.out), .oe_i(drv.oe), .level_i(level), .pad_o(pad));

  // Compare and count
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Port 2 control bits; outputs follow two edges later
  task automatic cfg2(input logic [6:0] s, input logic [6:0] d, input logic [4:0] a);
    cfg.port2_function_select_bits = s;
    cfg.port2_direction_bits = d;
    cfg.converter_analog_enable_bits = a;
    cyc(2);
  endtask

  task automatic t_reset();
    chk("drive in reset", drv, 16'h0000);
    chk("crystal in reset", xtal_c, 16'h0001);
    chk("resistor in reset", res_c, 16'h0000);
    reset_n_i = 1'b1;
    cyc(2);
    chk("drive after reset", drv, 16'h0000);
    chk("crystal after reset", xtal_c, 16'h0001);
  endtask

  task automatic t_gpio();
    cfg.port1_direction_bits = 1'b1;
    port_out = 8'hA5;
    cfg2(7'h00, 7'h7F, 5'h00);
    chk("gpio drive", drv, 16'hA5FF);
    cfg.port1_direction_bits = 1'b0;
    level = 8'h96;
    cfg2(7'h00, 7'h00, 5'h00);
    cyc(6);
    chk("gpio enables", drv.oe, 16'h0000);
    chk("gpio input", port_in, 16'h0096);
  endtask

  task automatic t_p17();
    level = 8'h01;
    cfg.test_port_active = 1'b1;
    cfg.port1_function_select_bits = 1'b1;
    per.test_data_oe = 1'b1;
    per.test_data_out = 1'b1;
    cyc(2);
    chk("test drive", {drv.oe[0], drv.out[0]}, 16'h0003);
    per.test_data_oe = 1'b0;
    cyc(6);
    chk("test input", {drv.oe[0], cap.test_data_in}, 16'h0001);
    cfg.test_port_active = 1'b0;
    cfg.port1_direction_bits = 1'b1;
    per.timer_compare_out_2 = 1'b1;
    cyc(2);
    chk("p1.7 compare", {drv.oe[0], drv.out[0]}, 16'h0003);
    per.timer_compare_out_2 = 1'b0;
    cyc(1);
    chk("p1.7 follows", {drv.oe[0], drv.out[0]}, 16'h0002);
  endtask

  task automatic t_p2out();
    logic [4:0] p;
    cfg2(7'h1F, 7'h1F, 5'h00);
    for (int i = 0; i < 2; i++) begin
      p = (i == 0) ? 5'h15 : 5'h0A;
      {per.timer_compare_out_2, per.timer_compare_out_1, per.timer_compare_out_0,
       per.subsystem_master_clock, per.aux_clock} = p;
      cyc(1);
      chk("p2 outputs", {drv.oe[5:1], drv.out[5:1]}, {6'h00, 5'h1F, p});
    end
  endtask

  task automatic t_capture();
    logic [7:0] lv;
    cfg.port1_direction_bits = 1'b0;
    cfg2(7'h2E, 7'h00, 5'h00);
    for (int i = 0; i < 2; i++) begin
      lv = (i == 0) ? 8'h6A : 8'h14;
      level = lv;
      cyc(6);
      chk("captures", {cap.timer_capture_in_0b, cap.timer_capture_in_1b,
        cap.timer_alt_clock_in}, {13'h0, lv[3], lv[4], lv[2]});
      chk("capture enables", drv.oe, 16'h0000);
    end
  endtask

  task automatic t_analog();
    level = 8'h3E;
    per = '1;
    cfg2(7'h1F, 7'h1F, 5'h1F);
    cyc(6);
    chk("analog drive", {drv.oe[5:1], drv.out[5:1]}, 16'h0000);
    cfg2(7'h1F, 7'h00, 5'h1F);
    chk("analog input", {port_in[5:1], cap.timer_capture_in_0b, cap.timer_capture_in_1b,
      cap.timer_alt_clock_in}, 16'h0000);
  endtask

  task automatic t_p25_p26();
    cfg.oscillator_external_resistor_select = 1'b1;
    port_out = 8'hFF;
    cfg2(7'h20, 7'h20, 5'h00);
    chk("resistor", {res_c, drv.oe[6]}, 16'h0002);
    cfg.oscillator_external_resistor_select = 1'b0;
    cyc(2);
    chk("ground", {res_c, drv.oe[6], drv.out[6]}, 16'h0002);
    cfg2(7'h40, 7'h40, 5'h00);
    chk("crystal", {xtal_c, drv.oe[7]}, 16'h0002);
    cfg2(7'h00, 7'h40, 5'h00);
    chk("p2.6 gpio", {xtal_c, drv.oe[7], drv.out[7]}, 16'h0003);
  endtask

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Reset defaults, then every scenario in turn
  initial begin
    cfg = '0;
    cfg.port2_function_select_bits = 7'h40;
    per = '0;
    port_out = 8'h00;
    level = 8'h00;
    cyc(6);
    t_reset();
    t_gpio();
    t_p17();
    t_p2out();
    t_capture();
    t_analog();
    t_p25_p26();
    summarize();
  end
endmodule // ppm_mux_bench
`default_nettype wire
